// [rtl/rstic_reset_irq_ctrl.sv]
// reset sequencing and interrupt vectoring for the processor core
// assumes the core issues I/O accesses, reports instruction boundaries and
// return-from-interrupt; the USB register groups sit outside and hand in levels
//
// Notes on behaviour
// - USB events reach vectors 13 or 2
// - frame events and bus/suspend events kept apart
// - reset pin low over 200 ns resets
// - watchdog pulse one cycle, delay follows
// - SE0 of 4 low-speed bits gives 24-cycle pulse
// - separation off: bus reset resets processor
// - separation on: USB only, masked interrupt
// - every USB reset deconfigures the device
// - processor reset clears registers, restart 000h
// - delay counts 1K or 16K watchdog ticks
// - power-on held until delay timer finishes
// - pin release waits for delay timer
// - taking interrupt clears global enable, return sets
// - static conditions set flag on edge only
// - vectoring clears the causing flag
// - disabled source still sets its flag
// - pending flags served later by priority
// - level interrupt has no latched flag
// - suspend enable plus global vectors to 002h
// - suspend flag cleared by vector or one
// - timer overflow enable plus global takes interrupt
// - lower vector address wins priority
// - vector runs no sooner than 4 cycles
`timescale 1ns/1ps

module rstic_reset_irq_ctrl
  import rstic_pkg::*;
#(
  parameter int DLY_FAST = DLY_FAST_TICKS,
  parameter int DLY_SLOW = DLY_SLOW_TICKS
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // pins and straps
  input  wire logic          rst_pin_n,
  input  wire logic          wdt_osc,
  input  wire logic          usb_se0,
  input  wire logic          fast_startup_fuse,
  // watchdog
  input  wire logic          wdt_enable,
  input  wire logic          wdt_expire,
  // USB register groups
  input  wire logic          bus_reset_sep_en,
  input  wire logic          bus_reset_irq_mask_bit,
  input  wire logic          usb_frame_irq_level,
  input  wire logic          susp_resume_cond,
  // timer
  input  wire logic          timer_overflow_event,
  // processor core
  input  wire rstic_io_req_t io_req,
  output logic [7:0]         io_rdata,
  input  wire logic          instr_boundary,
  input  wire logic          sw_gie_set,
  input  wire logic          sw_gie_clr,
  input  wire logic          return_from_interrupt,
  output logic               global_irq_enable,
  output logic               irq_busy,
  output logic               vec_fire,
  output rstic_vec_t         vec,
  // resets out
  output logic               cpu_rst,
  output logic [11:0]        cpu_start_addr,
  output logic               usb_hw_rst
);

  localparam int DW = $clog2(DLY_SLOW + 1);

  // refused at elaboration: the counter cannot serve these
  if (DLY_FAST < 1 || DLY_SLOW < DLY_FAST) begin : g_dly_chk
    $error("delay tick counts out of range");
  end

  // synchronisers
  logic [1:0] pin_sync;
  logic [1:0] osc_sync;
  logic [1:0] se0_sync;
  logic       osc_d;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync <= 2'h3;
      osc_sync <= 2'h0;
      se0_sync <= 2'h0;
      osc_d    <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], rst_pin_n};
      osc_sync <= {osc_sync[0], wdt_osc};
      se0_sync <= {se0_sync[0], usb_se0};
      osc_d    <= osc_sync[1];
    end
  end

  wire logic wdt_tick = osc_sync[1] & ~osc_d;

  // external reset filter
  logic [3:0] ext_cnt;
  wire logic  ext_low = (ext_cnt == 4'(EXT_RST_CYC));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_cnt <= 4'h0;
    end else if (pin_sync[1]) begin
      ext_cnt <= 4'h0;
    end else if (!ext_low) begin
      ext_cnt <= ext_cnt + 4'h1;
    end
  end

  // watchdog reset pulse, one cycle per expiry
  logic wdt_pulse;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_pulse <= 1'b0;
    end else begin
      wdt_pulse <= wdt_enable & wdt_expire & ~wdt_pulse;
    end
  end

  // USB bus reset detection and pulse
  logic [7:0] se0_cnt;
  logic [4:0] usb_pulse_cnt;
  wire logic  se0_hit    = se0_sync[1] && (se0_cnt == 8'(SE0_CYC - 1));
  wire logic  usb_pulse  = (usb_pulse_cnt != 5'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      se0_cnt <= 8'h0;
    end else if (!se0_sync[1]) begin
      se0_cnt <= 8'h0;
    end else if (se0_cnt != 8'(SE0_CYC)) begin
      se0_cnt <= se0_cnt + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_pulse_cnt <= 5'h0;
    end else if (se0_hit) begin
      usb_pulse_cnt <= 5'(USB_PULSE_CYC);
    end else if (usb_pulse) begin
      usb_pulse_cnt <= usb_pulse_cnt - 5'h1;
    end
  end

  // separation decides who the bus reset reaches
  wire logic usb_to_cpu = usb_pulse & ~bus_reset_sep_en;
  wire logic bus_irq_ev = se0_hit & bus_reset_sep_en & bus_reset_irq_mask_bit;

  // start-up delay timer on watchdog oscillator ticks
  logic          por_hold;
  logic          dly_done;
  logic [DW-1:0] dly_cnt;
  wire logic [DW-1:0] dly_target = fast_startup_fuse ? DW'(DLY_FAST) : DW'(DLY_SLOW);
  wire logic     src_active = por_hold | ext_low | wdt_pulse | usb_to_cpu;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_hold <= 1'b1;
    end else begin
      por_hold <= 1'b0;
    end
  end

  // any active source restarts the count; counting begins once all are gone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_cnt  <= '0;
      dly_done <= 1'b0;
    end else if (src_active) begin
      dly_cnt  <= '0;
      dly_done <= 1'b0;
    end else if (!dly_done && wdt_tick) begin
      dly_cnt  <= dly_cnt + DW'(1);
      dly_done <= (dly_cnt + DW'(1) == dly_target);
    end
  end

  assign cpu_rst        = src_active | ~dly_done;
  assign cpu_start_addr = RESET_VEC_ADDR;
  assign usb_hw_rst     = usb_pulse | cpu_rst;

  // interrupt sources
  logic susp_cond_d;
  logic susp_en;
  logic susp_flag;
  logic tovf_en;
  logic tovf_flag;
  logic gie;
  logic after_return_from_interrupt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      susp_cond_d <= 1'b0;
    end else begin
      susp_cond_d <= susp_resume_cond;
    end
  end

  // suspend group and bus reset share vector 2; frame group stays a level on 13
  wire logic susp_set = (susp_resume_cond & ~susp_cond_d) | bus_irq_ev;
  wire logic wr_gen_flags = io_req.we && (io_req.addr == GENERAL_IRQ_FLAGS_OFS);
  wire logic wr_tmr_flags = io_req.we && (io_req.addr == TIMER_IRQ_FLAGS_OFS);

  // arbitration
  wire logic req_susp = susp_flag & susp_en;
  wire logic req_tovf = tovf_flag & tovf_en;
  wire logic req_usb  = usb_frame_irq_level;
  wire logic any_req  = req_susp | req_tovf | req_usb;

  typedef enum logic {S_IDLE, S_RESP} rstic_state_t;
  rstic_state_t state;
  logic [1:0]   resp_cnt;
  wire logic    take = (state == S_IDLE) && gie && any_req && instr_boundary && !after_return_from_interrupt;

  function automatic rstic_vec_t rstic_pick(input logic s, input logic t);
    rstic_vec_t v;
    v = '{num: USB_VEC_NUM, addr: USB_VEC_ADDR};
    if (s) begin
      v = '{num: SUSP_VEC_NUM, addr: SUSP_VEC_ADDR};
    end else if (t) begin
      v = '{num: TOVF_VEC_NUM, addr: TOVF_VEC_ADDR};
    end
    return v;
  endfunction : rstic_pick

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= S_IDLE;
      resp_cnt <= 2'h0;
      vec      <= '0;
    end else if (cpu_rst) begin
      state    <= S_IDLE;
      resp_cnt <= 2'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (take) begin
            state    <= S_RESP;
            resp_cnt <= 2'h0;
            vec      <= rstic_pick(req_susp, req_tovf);
          end
        end
        S_RESP: begin
          resp_cnt <= resp_cnt + 2'h1;
          if (resp_cnt == 2'(RESP_CYC - 1)) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // pc push and stack adjust happen in the core while busy
  assign irq_busy = (state == S_RESP);
  assign vec_fire = irq_busy && (resp_cnt == 2'(RESP_CYC - 1));

  wire logic fire_susp = vec_fire && (vec.num == SUSP_VEC_NUM);
  wire logic fire_tovf = vec_fire && (vec.num == TOVF_VEC_NUM);

  // flags: a new event wins over a vector or write-one clear in the same cycle, not over processor reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      susp_flag <= 1'b0;
    end else if (cpu_rst) begin
      susp_flag <= 1'b0;
    end else if (susp_set) begin
      susp_flag <= 1'b1;
    end else if (fire_susp || (wr_gen_flags && io_req.wdata[SUSP_BIT])) begin
      susp_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tovf_flag <= 1'b0;
    end else if (cpu_rst) begin
      tovf_flag <= 1'b0;
    end else if (timer_overflow_event) begin
      tovf_flag <= 1'b1;
    end else if (fire_tovf || (wr_tmr_flags && io_req.wdata[TOVF_BIT])) begin
      tovf_flag <= 1'b0;
    end
  end

  // enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      susp_en <= 1'b0;
      tovf_en <= 1'b0;
    end else if (cpu_rst) begin
      susp_en <= REG_RESET[SUSP_BIT];
      tovf_en <= REG_RESET[TOVF_BIT];
    end else if (io_req.we) begin
      if (io_req.addr == GENERAL_IRQ_MASK_OFS) begin
        susp_en <= io_req.wdata[SUSP_BIT];
      end else if (io_req.addr == TIMER_IRQ_MASK_OFS) begin
        tovf_en <= io_req.wdata[TOVF_BIT];
      end
    end
  end

  // global enable; taking an interrupt outranks a software set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gie <= 1'b0;
    end else if (cpu_rst || take || sw_gie_clr) begin
      gie <= 1'b0;
    end else if (return_from_interrupt || sw_gie_set) begin
      gie <= 1'b1;
    end
  end

  // one more main-line instruction runs after a return
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      after_return_from_interrupt <= 1'b0;
    end else if (cpu_rst) begin
      after_return_from_interrupt <= 1'b0;
    end else if (return_from_interrupt) begin
      after_return_from_interrupt <= 1'b1;
    end else if (instr_boundary) begin
      after_return_from_interrupt <= 1'b0;
    end
  end

  assign global_irq_enable = gie;

  // register read, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 8'h00;
    end else if (io_req.re) begin
      if (io_req.addr == GENERAL_IRQ_MASK_OFS) begin
        io_rdata <= {1'b0, susp_en, 6'h00} & GEN_VALID_MASK;
      end else if (io_req.addr == GENERAL_IRQ_FLAGS_OFS) begin
        io_rdata <= {1'b0, susp_flag, 6'h00} & GEN_VALID_MASK;
      end else if (io_req.addr == TIMER_IRQ_MASK_OFS) begin
        io_rdata <= {6'h00, tovf_en, 1'b0} & TMR_VALID_MASK;
      end else if (io_req.addr == TIMER_IRQ_FLAGS_OFS) begin
        io_rdata <= {6'h00, tovf_flag, 1'b0} & TMR_VALID_MASK;
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  // checks
  logic [5:0] pulse_len;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_len <= 6'h0;
    end else begin
      pulse_len <= usb_pulse ? pulse_len + 6'h1 : 6'h0;
    end
  end

  sequence take_s;
    take;
  endsequence
  sequence resp_s;
    (irq_busy && !vec_fire) [*3] ##1 vec_fire;
  endsequence

  ext_filter_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!pin_sync[1]) [*8] |=> cpu_rst) else $error("long pin low gave no reset");
  wdt_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    wdt_pulse |=> !wdt_pulse && dly_cnt == '0 && cpu_rst) else $error("watchdog pulse wrong");
  usb_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(usb_pulse) && !se0_hit |-> $past(pulse_len) == 6'd23) else $error("usb pulse length");
  sep_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    usb_pulse && !bus_reset_sep_en |-> cpu_rst) else $error("bus reset missed processor");
  sep_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
    se0_hit && bus_reset_sep_en && bus_reset_irq_mask_bit && !cpu_rst |=> susp_flag)
    else $error("bus reset interrupt flag missing");
  gie_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    take |=> !gie) else $error("global enable survived take");
  resp_time_a: assert property (@(posedge clk) disable iff (!arst_n || cpu_rst)
    take_s |=> resp_s) else $error("vector not after four cycles");
  susp_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
    fire_susp && !susp_set && !cpu_rst |=> !susp_flag) else $error("flag not cleared");
  prio_pick_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req_susp |=> vec.addr == SUSP_VEC_ADDR) else $error("priority order broken");
  delay_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(cpu_rst) |-> $past(dly_cnt) + DW'(1) == $past(dly_target))
    else $error("delay ended early");

endmodule : rstic_reset_irq_ctrl

// [rtl/rstic_pkg.sv]
// constants, register map and carrier types for the reset and interrupt controller
// assumes a 40 MHz core clock and an 8-bit processor I/O space
package rstic_pkg;

  // clock and timing
  localparam int CLK_PS          = 25000;
  localparam int EXT_RST_NS      = 200;
  localparam int EXT_RST_CYC     = (EXT_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int LS_BIT_PS       = 666667;
  localparam int SE0_BITS        = 4;
  localparam int SE0_CYC         = (SE0_BITS * LS_BIT_PS + CLK_PS - 1) / CLK_PS;
  localparam int USB_PULSE_CYC   = 24;
  localparam int RESP_CYC        = 4;
  localparam int DLY_FAST_TICKS  = 1024;
  localparam int DLY_SLOW_TICKS  = 16384;

  // I/O offsets
  localparam logic [5:0] TIMER_IRQ_FLAGS_OFS   = 6'h38;
  localparam logic [5:0] TIMER_IRQ_MASK_OFS    = 6'h39;
  localparam logic [5:0] GENERAL_IRQ_FLAGS_OFS = 6'h3a;
  localparam logic [5:0] GENERAL_IRQ_MASK_OFS  = 6'h3b;

  // field positions
  localparam int SUSP_BIT      = 6;
  localparam int TOVF_BIT      = 1;
  localparam logic [7:0] GEN_VALID_MASK = 8'h40;
  localparam logic [7:0] TMR_VALID_MASK = 8'h02;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // vectors, word addresses and numbers
  localparam logic [11:0] RESET_VEC_ADDR = 12'h000;
  localparam logic [11:0] SUSP_VEC_ADDR  = 12'h002;
  localparam logic [11:0] TOVF_VEC_ADDR  = 12'h00e;
  localparam logic [11:0] USB_VEC_ADDR   = 12'h018;
  localparam logic [3:0]  SUSP_VEC_NUM   = 4'h2;
  localparam logic [3:0]  TOVF_VEC_NUM   = 4'h8;
  localparam logic [3:0]  USB_VEC_NUM    = 4'hd;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rstic_io_req_t;

  typedef struct packed {
    logic [3:0]  num;
    logic [11:0] addr;
  } rstic_vec_t;

endpackage : rstic_pkg

// [bench/rstic_core_model.sv]
// processor core stand-in: takes vectors, runs a short handler, returns
// assumes vec_fire is a one-cycle pulse and irq_busy covers the response
`timescale 1ns/1ps
module rstic_core_model (
  // clock
  input  wire logic clk,
  // controller side
  input  wire logic irq_busy,
  input  wire logic vec_fire,
  input  wire logic cpu_rst,
  output logic      instr_boundary = 1'b0,
  output logic      return_from_interrupt = 1'b0
);
  int hcnt = 0;

  // handler body is six cycles, long enough for the bench to act inside it
  always @(posedge clk) begin
    instr_boundary        <= !irq_busy && !cpu_rst;
    return_from_interrupt <= (hcnt == 1);
    if (vec_fire === 1'b1) begin
      hcnt <= 6;
    end else if (hcnt != 0) begin
      hcnt <= hcnt - 1;
    end
  end
endmodule : rstic_core_model

// [bench/rstic_reset_irq_ctrl_tb_top.sv]
// self-checking bench for the reset and interrupt controller
// assumes short delay counts and a slow free-running watchdog oscillator
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end

module reset_and_interrupt_control_tb_top
  import rstic_pkg::*;
;
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  logic          rst_pin_n = 1'b1;
  logic          wdt_osc = 1'b0;
  logic          usb_se0 = 1'b0;
  logic          fast_startup_fuse = 1'b1;
  logic          wdt_enable = 1'b0;
  logic          wdt_expire = 1'b0;
  logic          bus_reset_sep_en = 1'b0;
  logic          bus_reset_irq_mask_bit = 1'b0;
  logic          usb_frame_irq_level = 1'b0;
  logic          susp_resume_cond = 1'b0;
  logic          timer_overflow_event = 1'b0;
  rstic_io_req_t io_req = '0;
  logic          sw_gie_set = 1'b0;
  logic          sw_gie_clr = 1'b0;
  logic [7:0]    io_rdata;
  logic          instr_boundary, return_from_interrupt, global_irq_enable;
  logic          irq_busy, vec_fire, cpu_rst, usb_hw_rst;
  rstic_vec_t    vec;
  logic [11:0]   cpu_start_addr;
  logic [2:0]    wcnt = 3'h0;
  logic [3:0]    vq[$];
  int            miscompares = 0;
  int            checks_done = 0;
  int            cyc = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  // watchdog oscillator at one eighth of the core clock
  always @(posedge clk) begin
    wcnt    <= wcnt + 3'h1;
    wdt_osc <= wcnt[2];
    cyc     <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
    if (vec_fire === 1'b1) begin
      vq.push_back(vec.num);
      `CHK("gie at vector", 1'b0, global_irq_enable)
      `CHK("busy at vector", 1'b1, irq_busy)
    end
  end

  rstic_reset_irq_ctrl #(.DLY_FAST(2), .DLY_SLOW(4)) dut (
    .clk(clk), .arst_n(arst_n), .rst_pin_n(rst_pin_n), .wdt_osc(wdt_osc),
    .usb_se0(usb_se0), .fast_startup_fuse(fast_startup_fuse), .wdt_enable(wdt_enable),
    .wdt_expire(wdt_expire), .bus_reset_sep_en(bus_reset_sep_en),
    .bus_reset_irq_mask_bit(bus_reset_irq_mask_bit),
    .usb_frame_irq_level(usb_frame_irq_level), .susp_resume_cond(susp_resume_cond),
    .timer_overflow_event(timer_overflow_event), .io_req(io_req), .io_rdata(io_rdata),
    .instr_boundary(instr_boundary), .sw_gie_set(sw_gie_set), .sw_gie_clr(sw_gie_clr),
    .return_from_interrupt(return_from_interrupt), .global_irq_enable(global_irq_enable),
    .irq_busy(irq_busy), .vec_fire(vec_fire), .vec(vec), .cpu_rst(cpu_rst),
    .cpu_start_addr(cpu_start_addr), .usb_hw_rst(usb_hw_rst)
  );

  rstic_core_model core (
    .clk(clk), .irq_busy(irq_busy), .vec_fire(vec_fire), .cpu_rst(cpu_rst),
    .instr_boundary(instr_boundary), .return_from_interrupt(return_from_interrupt)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    io_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io_req <= '0;
    @(posedge clk);
  endtask : io_wr

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] e);
    io_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    io_req <= '0;
    @(posedge clk);
    `CHK(nm, e, io_rdata)
  endtask : rd_chk

  // one-cycle strobe; 0 watchdog expiry, 1 timer overflow, 2 gie set, 3 gie clear
  task automatic pulse(input int sel);
    case (sel)
      0: wdt_expire <= 1'b1;
      1: timer_overflow_event <= 1'b1;
      2: sw_gie_set <= 1'b1;
      default: sw_gie_clr <= 1'b1;
    endcase
    @(posedge clk);
    wdt_expire           <= 1'b0;
    timer_overflow_event <= 1'b0;
    sw_gie_set           <= 1'b0;
    sw_gie_clr           <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // bounded wait for processor reset to reach a level; n counts cycles
  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (cpu_rst !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("cpu_rst level", lvl, cpu_rst)
  endtask : wait_rst

  task automatic wdt_reset(output int n);
    pulse(0);
    `CHK("wdt reset", 1'b1, cpu_rst)
    wait_rst(1'b0, n);
  endtask : wdt_reset

  task automatic wait_vq(input int sz);
    int k;
    k = 0;
    while (vq.size() < sz && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_vq

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    int nf, ns, uc, cr;
    tick(12);
    arst_n <= 1'b1;
    wait_rst(1'b0, nf);
    `CHK("start addr", RESET_VEC_ADDR, cpu_start_addr)
    rd_chk("gen mask", GENERAL_IRQ_MASK_OFS, REG_RESET);
    io_wr(GENERAL_IRQ_MASK_OFS, 8'hff);
    rd_chk("gen mask bits", GENERAL_IRQ_MASK_OFS, GEN_VALID_MASK);
    io_wr(TIMER_IRQ_MASK_OFS, 8'hff);
    rd_chk("tmr mask bits", TIMER_IRQ_MASK_OFS, TMR_VALID_MASK);
    rd_chk("unmapped", 6'h10, 8'h00);
    $display("test registers done");
    susp_resume_cond <= 1'b1;
    tick(4);
    rd_chk("susp flag set", GENERAL_IRQ_FLAGS_OFS, 8'h40);
    io_wr(GENERAL_IRQ_FLAGS_OFS, 8'h40);
    rd_chk("susp flag w1c", GENERAL_IRQ_FLAGS_OFS, 8'h00);
    susp_resume_cond <= 1'b0;
    tick(4);
    susp_resume_cond <= 1'b1;
    tick(4);
    rd_chk("susp flag again", GENERAL_IRQ_FLAGS_OFS, 8'h40);
    pulse(1);
    rd_chk("tovf flag", TIMER_IRQ_FLAGS_OFS, 8'h02);
    $display("test flags done");
    pulse(2);
    wait_vq(2);
    tick(12);
    `CHK("first vector", SUSP_VEC_NUM, vq[0])
    `CHK("second vector", TOVF_VEC_NUM, vq[1])
    `CHK("gie after return", 1'b1, global_irq_enable)
    rd_chk("flags cleared", GENERAL_IRQ_FLAGS_OFS, 8'h00);
    rd_chk("tovf cleared", TIMER_IRQ_FLAGS_OFS, 8'h00);
    usb_frame_irq_level <= 1'b1;
    wait_vq(3);
    usb_frame_irq_level <= 1'b0;
    `CHK("usb vector", USB_VEC_NUM, vq[2])
    tick(12);
    pulse(3);
    $display("test vectors done");
    pulse(0);
    `CHK("wdt disabled", 1'b0, cpu_rst)
    wdt_enable <= 1'b1;
    wdt_reset(nf);
    rd_chk("mask after reset", GENERAL_IRQ_MASK_OFS, 8'h00);
    fast_startup_fuse <= 1'b0;
    wdt_reset(ns);
    `CHK("slow delay longer", 1'b1, ns > nf)
    fast_startup_fuse <= 1'b1;
    wdt_enable <= 1'b0;
    $display("test watchdog done");
    rst_pin_n <= 1'b0;
    tick(3);
    rst_pin_n <= 1'b1;
    tick(4);
    `CHK("short pin low", 1'b0, cpu_rst)
    rst_pin_n <= 1'b0;
    tick(20);
    `CHK("long pin low", 1'b1, cpu_rst)
    rst_pin_n <= 1'b1;
    tick(4);
    `CHK("pin delay", 1'b1, cpu_rst)
    wait_rst(1'b0, nf);
    $display("test pin done");
    usb_se0 <= 1'b1;
    tick(120);
    `CHK("bus reset cpu", 1'b1, cpu_rst)
    `CHK("bus reset usb", 1'b1, usb_hw_rst)
    usb_se0 <= 1'b0;
    wait_rst(1'b0, nf);
    io_wr(GENERAL_IRQ_FLAGS_OFS, 8'h40);
    bus_reset_sep_en <= 1'b1;
    bus_reset_irq_mask_bit <= 1'b1;
    usb_se0 <= 1'b1;
    uc = 0;
    cr = 0;
    for (int i = 0; i < 200; i++) begin
      if (i == 120) usb_se0 <= 1'b0;
      @(posedge clk);
      if (usb_hw_rst === 1'b1) uc++;
      if (cpu_rst === 1'b1) cr++;
    end
    `CHK("usb pulse len", USB_PULSE_CYC, uc)
    `CHK("separated cpu", 0, cr)
    rd_chk("bus irq flag", GENERAL_IRQ_FLAGS_OFS, 8'h40);
    $display("test usb reset done");
    give_verdict();
  end
endmodule : reset_and_interrupt_control_tb_top
